// ### rtl/cdt_pkg.sv
// Purpose: shared constants for the port 0 lane timing override bank
// Assumes: 32-bit AXI4-Lite, one register per aligned word
// Notes: register index times four gives the byte address
package cdt_pkg;

  // six timing registers, one per lane timing parameter
  localparam int CDT_NUM_FIELDS = 6;
  localparam int CDT_VAL_W = 7;
  localparam int CDT_OV_BIT = 7;
  localparam int CDT_REG_W = 8;

  // register indices; byte address is index shifted left by two
  localparam logic [7:0] CDT_IDX_CLOCK_PREPARE = 8'h40;
  localparam logic [7:0] CDT_IDX_CLOCK_ZERO = 8'h41;
  localparam logic [7:0] CDT_IDX_CLOCK_TRAIL = 8'h42;
  localparam logic [7:0] CDT_IDX_CLOCK_POST = 8'h43;
  localparam logic [7:0] CDT_IDX_DATA_PREPARE = 8'h44;
  localparam logic [7:0] CDT_IDX_DATA_ZERO = 8'h45;
  localparam logic [7:0] CDT_IDX_LANE_RATE = 8'h50;
  localparam logic [7:0] CDT_IDX_STATUS = 8'h51;
  localparam int CDT_IDX_LSB = 2;
  localparam int CDT_IDX_W = 8;

  localparam logic [7:0] CDT_FIELD_IDX [CDT_NUM_FIELDS] = '{
    CDT_IDX_CLOCK_PREPARE, CDT_IDX_CLOCK_ZERO, CDT_IDX_CLOCK_TRAIL,
    CDT_IDX_CLOCK_POST, CDT_IDX_DATA_PREPARE, CDT_IDX_DATA_ZERO};

  // reset values, those of the 800 Mbps lane rate
  localparam logic [6:0] CDT_FIELD_RST [CDT_NUM_FIELDS] = '{
    7'h05, 7'h1B, 7'h0B, 7'h0A, 7'h06, 7'h0C};

  // selectable lane rates
  localparam int CDT_RATE_COUNT = 5;
  localparam int CDT_RATE_W = 3;
  localparam int CDT_RATE_MBPS [CDT_RATE_COUNT] = '{400, 800, 1200, 1500, 1600};
  localparam int CDT_BASE_RATE_MBPS = 800;
  localparam logic [2:0] CDT_RATE_RST = 3'h1;
  localparam logic [6:0] CDT_VAL_MAX = 7'h7F;

  // status register layout
  localparam int CDT_STAT_RATE_LSB = 8;

  // AXI responses
  localparam logic [1:0] CDT_RESP_OKAY = 2'h0;
  localparam logic [1:0] CDT_RESP_SLVERR = 2'h2;

endpackage

// ### rtl/cdt_rate_table.sv
// Purpose: automatic lane timing values for the selected lane rate
// Assumes: rate code already checked against the rate count
// Notes: values scale from the 800 Mbps set and round up
`timescale 1ns/1ns
`default_nettype none
module cdt_rate_table
  import cdt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CDT_RATE_W-1:0] rate_code,
  output logic [CDT_RATE_W-1:0] rate_in_use_r,
  output logic [CDT_VAL_W-1:0] auto_val_r [CDT_NUM_FIELDS]
);

  // rounding up keeps each interval no shorter than the base value scaled
  function automatic logic [CDT_VAL_W-1:0] scale(input logic [CDT_VAL_W-1:0] base,
                                                 input int rate);
    int prod;
    prod = (int'(base) * rate + CDT_BASE_RATE_MBPS - 1) / CDT_BASE_RATE_MBPS;
    if (prod > int'(CDT_VAL_MAX)) begin
      return CDT_VAL_MAX;
    end
    return prod[CDT_VAL_W-1:0];
  endfunction

  // one registered lookup per field, recomputed on every rate change
  genvar i;
  generate
    for (i = 0; i < CDT_NUM_FIELDS; i++) begin : g_val
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          auto_val_r[i] <= CDT_FIELD_RST[i]; // R9
        end else begin
          auto_val_r[i] <= scale(CDT_FIELD_RST[i], CDT_RATE_MBPS[int'(rate_code)]); // R9
        end
      end
    end
  endgenerate

  // rate whose values currently stand in auto_val_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_in_use_r <= CDT_RATE_RST;
    end else begin
      rate_in_use_r <= rate_code;
    end
  end

endmodule // cdt_rate_table
`default_nettype wire

// ### rtl/cdt_timing_field.sv
// Purpose: one timing register, override flag plus 7-bit value
// Assumes: write enable already qualified by address and byte lane
// Notes: value_r always holds the value in use, auto or software
`timescale 1ns/1ns
`default_nettype none
module cdt_timing_field
  import cdt_pkg::*;
#(
  parameter logic [CDT_VAL_W-1:0] RESET_VAL = CDT_FIELD_RST[0]
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [CDT_REG_W-1:0] wr_data,
  input wire logic [CDT_VAL_W-1:0] auto_val,
  output logic override_r,
  output logic [CDT_VAL_W-1:0] value_r
);

  logic override_nxt;
  logic [CDT_VAL_W-1:0] value_nxt;
  logic wr_set;

  // bits 6:0 only land while the written override bit is one
  assign wr_set = wr_en && wr_data[CDT_OV_BIT];
  assign override_nxt = wr_en ? wr_data[CDT_OV_BIT] : override_r;
  assign value_nxt = wr_set ? wr_data[CDT_VAL_W-1:0] : // R8 R11
                     (override_nxt ? value_r : auto_val); // R7

  // tracking auto_val keeps reads and the lane on one flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      override_r <= 1'b0; // R10
      value_r <= RESET_VAL; // R9
    end else begin
      override_r <= override_nxt;
      value_r <= value_nxt;
    end
  end

endmodule // cdt_timing_field
`default_nettype wire

// ### rtl/cdt_top.sv
// Purpose: port 0 lane timing override register bank on AXI4-Lite
// Assumes: one clock, synchronous active-low reset, 32-bit data
// Notes: timing values leave on flops; unmapped addresses get SLVERR
// Behaviour
// R1: clock prepare: auto unless override bit set
// R2: clock zero: auto unless override bit set
// R3: clock trail: auto unless override bit set
// R4: clock post: auto unless override bit set
// R5: data prepare: auto unless override bit set
// R6: data zero: auto unless override bit set
// R7: override clear: value read-only, shows auto
// R8: override set: value is read/write storage
// R9: reset values for 800 Mbps; rate recomputes
// R10: all override bits reset to zero
// R11: override set: read and lane use written
`timescale 1ns/1ns
`default_nettype none
module cdt_top
  import cdt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [CDT_VAL_W-1:0] clock_prepare_value,
  output logic [CDT_VAL_W-1:0] clock_zero_value,
  output logic [CDT_VAL_W-1:0] clock_trail_value,
  output logic [CDT_VAL_W-1:0] clock_post_value,
  output logic [CDT_VAL_W-1:0] data_prepare_value,
  output logic [CDT_VAL_W-1:0] data_zero_value,
  output logic [CDT_RATE_W-1:0] lane_rate_code
);

  // write channel states: address and data may come in either order
  typedef enum logic [1:0] {
    CDT_WR_IDLE = 2'b00,
    CDT_WR_ADDR = 2'b01,
    CDT_WR_DATA = 2'b10,
    CDT_WR_RESP = 2'b11
  } cdt_wr_state_e;

  typedef enum logic {
    CDT_RD_IDLE = 1'b0,
    CDT_RD_DATA = 1'b1
  } cdt_rd_state_e;

  cdt_wr_state_e wr_state_r;
  cdt_wr_state_e wr_state_nxt;
  cdt_rd_state_e rd_state_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [CDT_RATE_W-1:0] rate_sel_r;
  logic [CDT_RATE_W-1:0] rate_in_use;
  logic [CDT_VAL_W-1:0] auto_val [CDT_NUM_FIELDS];
  logic [CDT_VAL_W-1:0] field_val [CDT_NUM_FIELDS];
  logic [CDT_NUM_FIELDS-1:0] field_ov;
  logic [CDT_NUM_FIELDS-1:0] field_wr;
  logic [CDT_NUM_FIELDS-1:0] field_rd_hit;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_mapped;
  logic rate_wr;
  logic rate_ok;
  logic rd_mapped;
  logic [31:0] rd_word;
  logic [31:0] field_word;
  // named decode terms, one set for the write path and one for the read path
  logic wr_lane_ok;
  logic wr_rate_hit;
  logic wr_stat_hit;
  logic rd_rate_hit;
  logic rd_stat_hit;
  logic [31:0] rate_word;
  logic [31:0] status_word;
  logic b_hs;
  logic r_hs;
  logic [1:0] wr_resp;
  logic [1:0] rd_resp;

  // address hits one register index; low two bits must be zero
  function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [CDT_IDX_W-1:0] idx);
    logic [ADDR_W-1:0] want;
    want = ADDR_W'(idx) << CDT_IDX_LSB;
    return addr == want;
  endfunction

  // any of the six timing registers
  function automatic logic [CDT_NUM_FIELDS-1:0] field_hits(input logic [ADDR_W-1:0] addr);
    logic [CDT_NUM_FIELDS-1:0] hits;
    hits = '0;
    for (int k = 0; k < CDT_NUM_FIELDS; k++) begin
      hits[k] = idx_hit(addr, CDT_FIELD_IDX[k]);
    end
    return hits;
  endfunction

  // handshakes
  assign s_axi_awready = (wr_state_r == CDT_WR_IDLE) || (wr_state_r == CDT_WR_DATA);
  assign s_axi_wready = (wr_state_r == CDT_WR_IDLE) || (wr_state_r == CDT_WR_ADDR);
  assign s_axi_bvalid = (wr_state_r == CDT_WR_RESP);
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = (rd_state_r == CDT_RD_IDLE);
  assign s_axi_rvalid = (rd_state_r == CDT_RD_DATA);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  // a beat on an answer channel ends the pending transfer
  assign b_hs = s_axi_bvalid && s_axi_bready;
  assign r_hs = s_axi_rvalid && s_axi_rready;

  // the write lands in the cycle its second half is taken
  assign do_write = (wr_state_r == CDT_WR_IDLE && aw_hs && w_hs) ||
                    (wr_state_r == CDT_WR_ADDR && w_hs) ||
                    (wr_state_r == CDT_WR_DATA && aw_hs);
  // a half taken now wins over the held copy
  assign wr_addr = aw_hs ? s_axi_awaddr : awaddr_r;
  assign wr_data = w_hs ? s_axi_wdata : wdata_r;
  assign wr_strb = w_hs ? s_axi_wstrb : wstrb_r;

  // write decode; only byte lane 0 carries register bits
  assign wr_lane_ok = do_write && wr_strb[0];
  assign wr_rate_hit = idx_hit(wr_addr, CDT_IDX_LANE_RATE);
  assign wr_stat_hit = idx_hit(wr_addr, CDT_IDX_STATUS);
  assign rate_wr = wr_lane_ok && wr_rate_hit;
  assign field_wr = wr_lane_ok ? field_hits(wr_addr) : '0;
  // the status word is read-only, yet a write to it still answers okay
  assign wr_mapped = (|field_hits(wr_addr)) || wr_rate_hit || wr_stat_hit;
  assign wr_resp = wr_mapped ? CDT_RESP_OKAY : CDT_RESP_SLVERR;
  // unsupported rate codes are dropped so the table never indexes past its end
  assign rate_ok = int'(wr_data[CDT_RATE_W-1:0]) < CDT_RATE_COUNT;

  // write channel next state
  always_comb begin
    wr_state_nxt = wr_state_r;
    unique case (wr_state_r)
      CDT_WR_IDLE: begin
        if (aw_hs && w_hs) begin
          wr_state_nxt = CDT_WR_RESP;
        end else if (aw_hs) begin
          wr_state_nxt = CDT_WR_ADDR;
        end else if (w_hs) begin
          wr_state_nxt = CDT_WR_DATA;
        end
      end
      CDT_WR_ADDR: begin
        if (w_hs) begin
          wr_state_nxt = CDT_WR_RESP;
        end
      end
      CDT_WR_DATA: begin
        if (aw_hs) begin
          wr_state_nxt = CDT_WR_RESP;
        end
      end
      CDT_WR_RESP: begin
        if (b_hs) begin
          wr_state_nxt = CDT_WR_IDLE;
        end
      end
    endcase
  end

  // write channel state and held halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= CDT_WR_IDLE;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bresp_r <= CDT_RESP_OKAY;
    end else begin
      wr_state_r <= wr_state_nxt;
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_r <= wr_resp;
      end
    end
  end

  // lane rate select; a change retriggers the automatic values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_sel_r <= CDT_RATE_RST; // R9
    end else if (rate_wr && rate_ok) begin
      rate_sel_r <= wr_data[CDT_RATE_W-1:0]; // R9
    end
  end

  // auto values trail the rate register by one cycle
  cdt_rate_table u_rate_table (
    .aclk(aclk),
    .aresetn(aresetn),
    .rate_code(rate_sel_r),
    .rate_in_use_r(rate_in_use),
    .auto_val_r(auto_val)
  );

  // six identical override fields, one per timing parameter
  genvar i;
  generate
    for (i = 0; i < CDT_NUM_FIELDS; i++) begin : g_field
      cdt_timing_field #(
        .RESET_VAL(CDT_FIELD_RST[i])
      ) u_field (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(field_wr[i]), // R7 R8
        .wr_data(wr_data[CDT_REG_W-1:0]),
        .auto_val(auto_val[i]),
        .override_r(field_ov[i]),
        .value_r(field_val[i])
      );
    end
  endgenerate

  // values applied to the lanes, from the field flops
  assign clock_prepare_value = field_val[0]; // R1
  assign clock_zero_value = field_val[1]; // R2
  assign clock_trail_value = field_val[2]; // R3
  assign clock_post_value = field_val[3]; // R4
  assign data_prepare_value = field_val[4]; // R5
  assign data_zero_value = field_val[5]; // R6
  assign lane_rate_code = rate_in_use;

  // read mux; at most one field hits, so an or-reduce is safe
  assign field_rd_hit = field_hits(s_axi_araddr);
  always_comb begin
    field_word = '0;
    for (int k = 0; k < CDT_NUM_FIELDS; k++) begin
      if (field_rd_hit[k]) begin
        field_word = field_word | 32'({field_ov[k], field_val[k]}); // R7 R11
      end
    end
  end

  // read decode; the rate register shows the selected code, status the code in use
  assign rd_rate_hit = idx_hit(s_axi_araddr, CDT_IDX_LANE_RATE);
  assign rd_stat_hit = idx_hit(s_axi_araddr, CDT_IDX_STATUS);
  assign rd_mapped = (|field_rd_hit) || rd_rate_hit || rd_stat_hit;
  assign rd_resp = rd_mapped ? CDT_RESP_OKAY : CDT_RESP_SLVERR;
  assign rate_word = 32'(rate_sel_r);
  assign status_word = 32'(field_ov) | (32'(rate_in_use) << CDT_STAT_RATE_LSB);
  // unmapped reads return zero beside the error response
  assign rd_word = (|field_rd_hit) ? field_word :
                   rd_rate_hit ? rate_word :
                   rd_stat_hit ? status_word :
                   32'h0000_0000;

  // read channel: data captured when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= CDT_RD_IDLE;
      rdata_r <= '0;
      rresp_r <= CDT_RESP_OKAY;
    end else if (ar_hs) begin
      rd_state_r <= CDT_RD_DATA;
      rdata_r <= rd_word;
      rresp_r <= rd_resp;
    end else if (r_hs) begin
      rd_state_r <= CDT_RD_IDLE;
    end
  end

endmodule // cdt_top
`default_nettype wire

// ### testbench/cdt_props.sv
// Purpose: port-level checks for the lane timing override bank
// Assumes: the master offers write address and data together
// Notes: one clock domain, so default clocking and disable are used
`timescale 1ns/1ns
`default_nettype none
module cdt_props
  import cdt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CDT_VAL_W-1:0] clock_prepare_value,
  input wire logic [CDT_VAL_W-1:0] clock_zero_value,
  input wire logic [CDT_VAL_W-1:0] clock_trail_value,
  input wire logic [CDT_VAL_W-1:0] clock_post_value,
  input wire logic [CDT_VAL_W-1:0] data_prepare_value,
  input wire logic [CDT_VAL_W-1:0] data_zero_value
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // write taken whole in one edge; all six values as one vector
  wire logic wr_take;
  wire logic [41:0] vals;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign vals = {clock_prepare_value, clock_zero_value, clock_trail_value,
    clock_post_value, data_prepare_value, data_zero_value};
  chk_write_answer: assert property (wr_take |=> s_axi_bvalid)
    else $error("write answer missing");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  chk_reset_values: assert property ($rose(aresetn) |-> vals == {7'h05, 7'h1B, 7'h0B, 7'h0A,
    7'h06, 7'h0C}) else $error("timing outputs not at reset values");
  chk_prep_override: assert property (wr_take && s_axi_awaddr == 12'h100 && s_axi_wdata[7]
    |-> ##2 clock_prepare_value == $past(s_axi_wdata[6:0], 2)) else $error("prepare override lost");
  chk_zero_override: assert property (wr_take && s_axi_awaddr == 12'h114 && s_axi_wdata[7]
    |-> ##2 data_zero_value == $past(s_axi_wdata[6:0], 2)) else $error("data zero override lost");
  // values may only move within three edges of a write
  chk_values_steady: assert property (!$past(wr_take) && !$past(wr_take, 2) &&
    !$past(wr_take, 3) |-> $stable(vals)) else $error("timing value moved without a write");
  chk_read_data: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h100
    |=> s_axi_rdata[6:0] == $past(clock_prepare_value)) else $error("read differs from value in use");
endmodule // cdt_props
bind cdt_top cdt_props #(.ADDR_W(ADDR_W)) u_props (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .clock_prepare_value, .clock_zero_value, .clock_trail_value,
  .clock_post_value, .data_prepare_value, .data_zero_value);
`default_nettype wire

// ### testbench/cdt_top_bench.sv
// Purpose: self-checking bench for the lane timing override bank
// Assumes: answers come whenever the slave is ready; bench waits
// Notes: ready signals raised a cycle late so hold behaviour is seen
`timescale 1ns/1ns
`default_nettype none
module cdt_top_bench
  import cdt_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} cdt_row_s;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [6:0] outs [6];
  wire [2:0] lane_rate_code;
  int err_count, n_checks, i;
  // address, write data, read-back, response for both
  cdt_row_s rows [10] = '{'{12'h100, 32'hFF, 32'hFF, CDT_RESP_OKAY},
    '{12'h104, 32'h81, 32'h81, CDT_RESP_OKAY}, '{12'h108, 32'hC4, 32'hC4, CDT_RESP_OKAY},
    '{12'h10C, 32'h80, 32'h80, CDT_RESP_OKAY}, '{12'h110, 32'h9A, 32'h9A, CDT_RESP_OKAY},
    '{12'h114, 32'h2A5, 32'hA5, CDT_RESP_OKAY}, '{12'h100, 32'h0, 32'h05, CDT_RESP_OKAY},
    '{12'h104, 32'h7F, 32'h1B, CDT_RESP_OKAY}, '{12'h0F0, 32'h80, 32'h0, CDT_RESP_SLVERR},
    '{12'h101, 32'h80, 32'h0, CDT_RESP_SLVERR}};
  cdt_top #(.ADDR_W(12)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .clock_prepare_value(outs[0]), .clock_zero_value(outs[1]), .clock_trail_value(outs[2]),
    .clock_post_value(outs[3]), .data_prepare_value(outs[4]), .data_zero_value(outs[5]),
    .lane_rate_code);
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] dd, output logic [1:0] rs);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] dd, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    dd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // six cycles low, first request one edge after release
  task automatic rst();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // hang guard, far beyond the roughly 120 cycles needed
  initial begin
    repeat (4000) @(posedge aclk);
    err_count++;
    summarize();
  end
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hF;
    @(posedge aclk);
    rst();
    for (i = 0; i < 6; i++) begin
      rd(12'({CDT_FIELD_IDX[i], 2'h0}), d, r);
      check("reset read", 32'(CDT_FIELD_RST[i]), d);
      check("reset out", 32'(CDT_FIELD_RST[i]), 32'(outs[i]));
    end
    for (i = 0; i < 10; i++) begin
      wr(rows[i].a, rows[i].d, r);
      check("write resp", 32'(rows[i].r), 32'(r));
      rd(rows[i].a, d, r);
      check("read resp", 32'(rows[i].r), 32'(r));
      check("read data", rows[i].e, d);
      if (rows[i].a >= 12'h100 && rows[i].a < 12'h118 && rows[i].a[1:0] == 2'h0)
        check("lane out", 32'(rows[i].e[6:0]), 32'(outs[(rows[i].a - 12'h100) >> 2]));
    end
    // slower lane rate: auto fields follow, overridden ones hold
    wr(12'h140, 32'h0, r);
    check("rate resp", 32'(CDT_RESP_OKAY), 32'(r));
    repeat (3) @(posedge aclk);
    check("rate code", 32'h0, 32'(lane_rate_code));
    check("auto prepare", 32'h03, 32'(outs[0]));
    check("auto zero", 32'h0E, 32'(outs[1]));
    check("held trail", 32'h44, 32'(outs[2]));
    wr(12'h10C, 32'h7F, r);
    rd(12'h10C, d, r);
    check("post back to auto", 32'h05, d);
    check("post out", 32'h05, 32'(outs[3]));
    // unsupported rate code leaves the rate alone; status shows flags and rate
    wr(12'h140, 32'h7, r);
    check("bad rate resp", 32'(CDT_RESP_OKAY), 32'(r));
    rd(12'h140, d, r);
    check("rate kept", 32'h0, d);
    check("rate in use kept", 32'h0, 32'(lane_rate_code));
    rd(12'h144, d, r);
    check("status", 32'h34, d);
    // second reset in mid-run
    rst();
    rd(12'h114, d, r);
    check("zero after reset", 32'h0C, d);
    check("rate after reset", 32'(CDT_RATE_RST), 32'(lane_rate_code));
    summarize();
  end
endmodule // cdt_top_bench
`default_nettype wire
